// ### logic/flash_cmd_params.svh
// constants for the flash write-latch and block-lock command block
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH
`define OPC_WRITE_ENABLE 8'h06
`define OPC_WRITE_DISABLE 8'h04
`define OPC_VOL_ENABLE 8'h50
`define OPC_BLOCK_LOCK 8'h36
`define OPC_BLOCK_UNLOCK 8'h39
`define OPC_STATUS_WRITE 8'h01
`define OPC_STATUS_WRITE_2 8'h31
`define OPC_STATUS_WRITE_3 8'h11
`define OPC_STATUS_WRITE_4 8'h71
`define OPC_PROGRAM 8'h02
`define OPC_PROGRAM_DUAL 8'hA2
`define OPC_PROGRAM_QUAD 8'h32
`define OPC_PROGRAM_SEQ_A 8'hAF
`define OPC_PROGRAM_SEQ_B 8'hAD
`define OPC_ERASE_4K 8'h20
`define OPC_ERASE_32K 8'h52
`define OPC_ERASE_64K 8'hD8
`define OPC_ERASE_CHIP_A 8'h60
`define OPC_ERASE_CHIP_B 8'hC7
`define OPC_OTP_PROGRAM 8'h9B
`define BITS_PER_BYTE 8
`define ADDR_BYTES 3
`define BLOCK_SHIFT 12
`define LOCK_RESET_VALUE 1'b1
`endif

// ### logic/flash_cmd_pkg.sv
// types shared by the flash command block
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPCODE = 2'b01,
    ST_ADDR = 2'b10,
    ST_TAIL = 2'b11
  } cmd_state_e;
  typedef enum logic [1:0] {
    CL_OTHER = 2'b00,
    CL_GUARDED = 2'b01,
    CL_STATUS_WRITE = 2'b10,
    CL_ARRAY_WRITE = 2'b11
  } cmd_class_e;
endpackage

// ### logic/serial_shift_in.sv
// msb-first serial shifter with bit counter, restarted at chip select assertion
`include "flash_cmd_params.svh"
module serial_shift_in #(
  parameter int CNT_W = 6
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic bit_valid_i,
  input wire logic bit_i,
  output logic [31:0] shift_o,
  output logic [CNT_W-1:0] count_o
);
  logic [31:0] shift_ff;
  logic [31:0] nxt_shift;
  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;

  // counter saturates so a long frame cannot wrap back to a byte boundary alias
  always_comb begin
    nxt_shift = shift_ff;
    nxt_count = count_ff;
    if (start_i) begin
      nxt_shift = 32'h0000_0000;
      nxt_count = '0;
    end else if (bit_valid_i) begin
      nxt_shift = {shift_ff[30:0], bit_i};
      if (count_ff != {CNT_W{1'b1}}) begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      shift_ff <= 32'h0000_0000;
      count_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
    end
  end

  assign shift_o = shift_ff;
  assign count_o = count_ff;
endmodule

// ### logic/block_lock_array.sv
// per-block lock bits, one flip-flop per 4 kB region
`include "flash_cmd_params.svh"
module block_lock_array #(
  parameter int NUM_BLOCKS = 128,
  parameter int IDX_W = 7
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic wr_i,
  input wire logic [IDX_W-1:0] wr_idx_i,
  input wire logic wr_val_i,
  input wire logic [IDX_W-1:0] rd_idx_i,
  output logic rd_val_o
);
  logic [NUM_BLOCKS-1:0] lock_ff;
  logic [NUM_BLOCKS-1:0] nxt_lock;

  // one write port; the index picks the block
  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++) begin : g_lock
      always_comb begin
        nxt_lock[g] = lock_ff[g];
        if (wr_i && (wr_idx_i == IDX_W'(g))) begin
          nxt_lock[g] = wr_val_i;
        end
      end
    end
  endgenerate

  // every region starts protected
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      lock_ff <= {NUM_BLOCKS{`LOCK_RESET_VALUE}};
    end else begin
      lock_ff <= nxt_lock;
    end
  end

  assign rd_val_o = lock_ff[rd_idx_i];
endmodule

// ### logic/flash_write_latch_block_lock.sv
// command decoder for write latch, volatile status enable and per-block locking
// Functional notes
// - chip select rising off a byte boundary aborts with no effect
// - opcode 04h clears the write enable latch at chip select rise
// - latch clear refuses program, erase and otp program commands, and status write commands unless volatile enable is pending
// - 04h and 50h are opcode-only, no address or data
// - opcodes are eight serial clocks, msb first
// - 50h never sets the write enable latch
// - volatile enable covers only a status write sent as the very next command, then is consumed
// - 36h lock: opcode then three address bytes, msb A23 first
// - 39h unlock: opcode then three address bytes, msb first
// - lock and unlock need the latch set beforehand, else refused
// - valid lock/unlock updates the addressed bit then clears the latch
// - lock bits protect only with block_protect_select set, else range fields
// - all lock bits reset to one, every block locked against program and 4K/32K/64K erase
// - address selects block; program/erase to a locked block is rejected
// - opcode 06h sets the write enable latch at chip select rise
// - one lock bit per 4 kB region, address bits above the low twelve
`include "flash_cmd_params.svh"
module flash_write_latch_block_lock
  import flash_cmd_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int NUM_BLOCKS = 128
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic sclk_rise_i,
  input wire logic si_i,
  input wire logic block_protect_select_i,
  input wire logic range_protected_i,
  output logic write_enable_latch_o,
  output logic volatile_enable_o,
  output logic cmd_exec_o,
  output logic [7:0] cmd_opcode_o,
  output logic [23:0] cmd_addr_o,
  output logic cmd_volatile_o,
  output logic cmd_refused_o,
  output logic cmd_aborted_o
);
  localparam int IDX_W = ADDR_W - `BLOCK_SHIFT;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] OPC_BITS = CNT_W'(`BITS_PER_BYTE);
  localparam logic [CNT_W-1:0] ADDR_BITS = CNT_W'(`BITS_PER_BYTE * (`ADDR_BYTES + 1));

  logic cs_n_ff;
  logic start;
  logic cs_rise;
  logic [31:0] shift;
  logic [CNT_W-1:0] bit_count;
  logic [7:0] opcode_ff;
  logic [7:0] nxt_opcode;
  cmd_state_e state_ff;
  cmd_state_e nxt_state;
  logic wel_ff;
  logic nxt_wel;
  logic vol_ff;
  logic nxt_vol;
  logic exec_ff;
  logic nxt_exec;
  logic [7:0] exec_opc_ff;
  logic [7:0] nxt_exec_opc;
  logic [23:0] exec_addr_ff;
  logic [23:0] nxt_exec_addr;
  logic exec_vol_ff;
  logic nxt_exec_vol;
  logic refused_ff;
  logic nxt_refused;
  logic aborted_ff;
  logic nxt_aborted;
  logic lock_wr;
  logic lock_val;
  logic [IDX_W-1:0] lock_wr_idx;
  logic block_locked;
  logic [23:0] frame_addr;
  logic byte_aligned;
  cmd_class_e opc_class;

  // chip select edges; the pin is taken as synchronous to ref_clk_i
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cs_n_ff <= 1'b1;
    end else begin
      cs_n_ff <= cs_n_i;
    end
  end
  assign start = cs_n_ff && !cs_n_i;
  assign cs_rise = !cs_n_ff && cs_n_i;

  // msb-first shift of opcode and address
  serial_shift_in #(
    .CNT_W(CNT_W)
  ) u_shift (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(start),
    .bit_valid_i(sclk_rise_i && !cs_n_i),
    .bit_i(si_i),
    .shift_o(shift),
    .count_o(bit_count)
  );

  assign frame_addr = shift[23:0];
  assign byte_aligned = (bit_count[2:0] == 3'b000);

  // block index from address bits above the low twelve
  assign lock_wr_idx = frame_addr[ADDR_W-1:`BLOCK_SHIFT];

  block_lock_array #(
    .NUM_BLOCKS(NUM_BLOCKS),
    .IDX_W(IDX_W)
  ) u_locks (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .wr_i(lock_wr),
    .wr_idx_i(lock_wr_idx),
    .wr_val_i(lock_val),
    .rd_idx_i(lock_wr_idx),
    .rd_val_o(block_locked)
  );

  // classify the opcode by what the latch guards
  always_comb begin
    case (opcode_ff)
      `OPC_STATUS_WRITE, `OPC_STATUS_WRITE_2, `OPC_STATUS_WRITE_3,
      `OPC_STATUS_WRITE_4: opc_class = CL_STATUS_WRITE;
      `OPC_PROGRAM, `OPC_PROGRAM_DUAL, `OPC_PROGRAM_QUAD, `OPC_PROGRAM_SEQ_A,
      `OPC_PROGRAM_SEQ_B, `OPC_ERASE_4K, `OPC_ERASE_32K, `OPC_ERASE_64K: begin
        opc_class = CL_ARRAY_WRITE;
      end
      `OPC_ERASE_CHIP_A, `OPC_ERASE_CHIP_B, `OPC_OTP_PROGRAM: opc_class = CL_GUARDED;
      default: opc_class = CL_OTHER;
    endcase
  end

  // frame phase tracking; opcode latched once eight bits are in
  always_comb begin
    nxt_state = state_ff;
    nxt_opcode = opcode_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_OPCODE;
        end
      end
      ST_OPCODE: begin
        if (cs_rise) begin
          nxt_state = ST_IDLE;
        end else if (bit_count == OPC_BITS) begin
          nxt_opcode = shift[7:0];
          nxt_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (cs_rise) begin
          nxt_state = ST_IDLE;
        end else if (bit_count == ADDR_BITS) begin
          nxt_state = ST_TAIL;
        end
      end
      ST_TAIL: begin
        if (cs_rise) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (start) begin
      nxt_opcode = 8'h00;
    end
  end

  // command completion at chip select rise
  always_comb begin
    nxt_wel = wel_ff;
    nxt_vol = vol_ff;
    nxt_exec = 1'b0;
    nxt_exec_opc = exec_opc_ff;
    nxt_exec_addr = exec_addr_ff;
    nxt_exec_vol = exec_vol_ff;
    nxt_refused = 1'b0;
    nxt_aborted = 1'b0;
    lock_wr = 1'b0;
    lock_val = 1'b0;
    if (cs_rise && state_ff != ST_IDLE) begin
      if (!byte_aligned || state_ff == ST_OPCODE) begin
        nxt_aborted = 1'b1; // no effect on any state
      end else begin
        case (opcode_ff)
          `OPC_WRITE_ENABLE: begin
            if (bit_count == OPC_BITS) begin
              nxt_wel = 1'b1;
              nxt_vol = 1'b0;
            end else begin
              nxt_aborted = 1'b1;
            end
          end
          `OPC_WRITE_DISABLE: begin
            if (bit_count == OPC_BITS) begin
              nxt_wel = 1'b0;
              nxt_vol = 1'b0;
            end else begin
              nxt_aborted = 1'b1;
            end
          end
          `OPC_VOL_ENABLE: begin
            if (bit_count == OPC_BITS) begin
              nxt_vol = 1'b1; // latch untouched
            end else begin
              nxt_aborted = 1'b1;
            end
          end
          `OPC_BLOCK_LOCK, `OPC_BLOCK_UNLOCK: begin
            // up to three whole bytes past the address are accepted, and the address is then taken from the last three bytes shifted in
            if (state_ff != ST_TAIL) begin
              nxt_aborted = 1'b1; // address incomplete
            end else if (!wel_ff) begin
              nxt_refused = 1'b1;
              nxt_vol = 1'b0;
            end else begin
              lock_wr = 1'b1;
              lock_val = (opcode_ff == `OPC_BLOCK_LOCK);
              // reported like any guarded command so the host side can see it ran
              nxt_exec = 1'b1;
              nxt_exec_vol = 1'b0;
              nxt_wel = 1'b0;
              nxt_vol = 1'b0;
            end
          end
          default: begin
            nxt_vol = 1'b0;
            if (opc_class == CL_STATUS_WRITE) begin
              // a volatile status write needs no latch
              if (wel_ff || vol_ff) begin
                nxt_exec = 1'b1;
                nxt_exec_vol = vol_ff;
                nxt_wel = 1'b0;
              end else begin
                nxt_refused = 1'b1;
              end
            end else if (opc_class == CL_GUARDED || opc_class == CL_ARRAY_WRITE) begin
              if (!wel_ff) begin
                nxt_refused = 1'b1;
              end else if (opc_class == CL_ARRAY_WRITE && state_ff != ST_TAIL) begin
                nxt_aborted = 1'b1;
              end else if (opc_class == CL_ARRAY_WRITE &&
                           (block_protect_select_i ? block_locked : range_protected_i)) begin
                nxt_refused = 1'b1;
                nxt_wel = 1'b0;
              end else begin
                nxt_exec = 1'b1;
                nxt_exec_vol = 1'b0;
                nxt_wel = 1'b0;
              end
            end
          end
        endcase
        if (nxt_exec) begin
          nxt_exec_opc = opcode_ff;
          nxt_exec_addr = frame_addr;
        end
      end
    end
  end

  // frame, latch and result state registered here
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      opcode_ff <= 8'h00;
      wel_ff <= 1'b0;
      vol_ff <= 1'b0;
      exec_ff <= 1'b0;
      exec_opc_ff <= 8'h00;
      exec_addr_ff <= 24'h00_0000;
      exec_vol_ff <= 1'b0;
      refused_ff <= 1'b0;
      aborted_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      opcode_ff <= nxt_opcode;
      wel_ff <= nxt_wel;
      vol_ff <= nxt_vol;
      exec_ff <= nxt_exec;
      exec_opc_ff <= nxt_exec_opc;
      exec_addr_ff <= nxt_exec_addr;
      exec_vol_ff <= nxt_exec_vol;
      refused_ff <= nxt_refused;
      aborted_ff <= nxt_aborted;
    end
  end

  assign write_enable_latch_o = wel_ff;
  assign volatile_enable_o = vol_ff;
  assign cmd_exec_o = exec_ff;
  assign cmd_opcode_o = exec_opc_ff;
  assign cmd_addr_o = exec_addr_ff;
  assign cmd_volatile_o = exec_vol_ff;
  assign cmd_refused_o = refused_ff;
  assign cmd_aborted_o = aborted_ff;
endmodule

// ### tb/flash_cmd_sva.sv
// concurrent checks on the ports of the flash command block
`include "flash_cmd_params.svh"
module flash_cmd_sva (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic cs_n_i,
  input wire logic write_enable_latch_o,
  input wire logic volatile_enable_o,
  input wire logic cmd_exec_o,
  input wire logic [7:0] cmd_opcode_o,
  input wire logic cmd_volatile_o,
  input wire logic cmd_refused_o,
  input wire logic cmd_aborted_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // the latch only moves once the frame has ended, never mid-frame
  property p_latch_at_cs_rise;
    $changed(write_enable_latch_o) |-> $past(cs_n_i);
  endproperty
  a_latch_at_cs_rise: assert property (p_latch_at_cs_rise) else $error("latch moved in frame");
  property p_abort_no_effect;
    cmd_aborted_o |-> $stable(write_enable_latch_o) && $stable(volatile_enable_o)
      && !cmd_exec_o && !cmd_refused_o;
  endproperty
  a_abort_no_effect: assert property (p_abort_no_effect) else $error("abort had effect");
  property p_exec_needs_latch;
    cmd_exec_o && !cmd_volatile_o |-> $past(write_enable_latch_o);
  endproperty
  a_exec_needs_latch: assert property (p_exec_needs_latch) else $error("ran without latch");
  property p_refused_latch_clear;
    cmd_refused_o |-> !write_enable_latch_o && !cmd_exec_o;
  endproperty
  a_refused_latch_clear: assert property (p_refused_latch_clear) else $error("bad refusal");
  property p_vol_no_latch;
    $rose(volatile_enable_o) |-> $stable(write_enable_latch_o);
  endproperty
  a_vol_no_latch: assert property (p_vol_no_latch) else $error("volatile enable hit latch");
  property p_vol_consumed;
    cmd_exec_o && cmd_volatile_o |-> !volatile_enable_o && $past(volatile_enable_o);
  endproperty
  a_vol_consumed: assert property (p_vol_consumed) else $error("volatile enable kept");
  property p_lock_clears_latch;
    cmd_exec_o && (cmd_opcode_o == `OPC_BLOCK_LOCK || cmd_opcode_o == `OPC_BLOCK_UNLOCK)
      |-> !write_enable_latch_o;
  endproperty
  a_lock_clears_latch: assert property (p_lock_clears_latch) else $error("lock kept latch");
  property p_vol_drop;
    $rose(write_enable_latch_o) |-> !volatile_enable_o;
  endproperty
  a_vol_drop: assert property (p_vol_drop) else $error("volatile enable survived");
endmodule
bind flash_write_latch_block_lock flash_cmd_sva u_sva (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .cs_n_i(cs_n_i),
  .write_enable_latch_o(write_enable_latch_o),
  .volatile_enable_o(volatile_enable_o),
  .cmd_exec_o(cmd_exec_o),
  .cmd_opcode_o(cmd_opcode_o),
  .cmd_volatile_o(cmd_volatile_o),
  .cmd_refused_o(cmd_refused_o),
  .cmd_aborted_o(cmd_aborted_o)
);

// ### tb/host_spi_model.sv
// host controller model shifting commands in msb first
module host_spi_model (
  input wire logic ref_clk_i,
  output logic cs_n_o,
  output logic sclk_rise_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bit_q = 1'b0;
  logic idle_q = 1'b0;
  initial cs_n_o = 1'b1;
  initial sclk_rise_o = 1'b0;
  // a deselected line toggles so a stale bit can never pass for data
  always @(posedge ref_clk_i) idle_q <= ~idle_q;
  assign si_o = cs_n_o ? idle_q : bit_q;
  // whole frame before chip select rises, one bit per two cycles
  task automatic send(input logic [31:0] word, input int nbits);
    @(posedge ref_clk_i) cs_n_o <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      @(posedge ref_clk_i) sclk_rise_o <= 1'b1;
      bit_q <= word[31-i];
      @(posedge ref_clk_i) sclk_rise_o <= 1'b0;
    end
    @(posedge ref_clk_i) cs_n_o <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule

// ### tb/tb_flash_write_latch_block_lock.sv
// self-checking bench for the flash command block
`include "flash_cmd_params.svh"
module tb_flash_write_latch_block_lock;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic cs_n, sclk_rise, si, latch, vol, exec, cvol, refd, abt;
  logic bps = 1'b1;
  logic rng = 1'b0;
  logic [7:0] op;
  logic [23:0] addr, a;
  logic [6:0] b;
  logic locks [128];
  logic [7:0] gops [15] = '{8'h02, 8'hA2, 8'h32, 8'hAF, 8'hAD, 8'h20, 8'h52, 8'hD8,
    8'h60, 8'hC7, 8'h9B, 8'h01, 8'h31, 8'h11, 8'h71};
  int fails = 0;
  int n_compared = 0;
  initial forever #10 ref_clk_i = ~ref_clk_i;
  host_spi_model u_host (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .sclk_rise_o(sclk_rise),
    .si_o(si));
  flash_write_latch_block_lock u_dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .cs_n_i(cs_n), .sclk_rise_i(sclk_rise), .si_i(si), .block_protect_select_i(bps),
    .range_protected_i(rng), .write_enable_latch_o(latch), .volatile_enable_o(vol),
    .cmd_exec_o(exec), .cmd_opcode_o(op), .cmd_addr_o(addr), .cmd_volatile_o(cvol),
    .cmd_refused_o(refd), .cmd_aborted_o(abt));
  int n_exec = 0;
  int n_ref = 0;
  int n_abt = 0;
  // pulses are counted, so their exact cycle after cs rise does not matter but repeats do
  always @(posedge ref_clk_i) begin
    if (exec === 1'b1) n_exec <= n_exec + 1;
    if (refd === 1'b1) n_ref <= n_ref + 1;
    if (abt === 1'b1) n_abt <= n_abt + 1;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one frame; each pulse must show up exactly as often as expected, none or once
  task automatic cmd(input logic [7:0] o, input logic [23:0] ad, input int nb,
                     input logic e_exec, input logic e_ref, input logic e_abt);
    int e0;
    int r0;
    int b0;
    e0 = n_exec;
    r0 = n_ref;
    b0 = n_abt;
    u_host.send({o, ad}, nb);
    check(32'(n_exec - e0), e_exec);
    check(32'(n_ref - r0), e_ref);
    check(32'(n_abt - b0), e_abt);
  endtask
  function automatic logic prog_ok(input logic l, input logic [6:0] blk);
    return l && (bps ? !locks[blk] : !rng);
  endfunction
  initial begin
    void'($urandom(32'h9AE8EC66));
    foreach (locks[i]) locks[i] = 1'b1;
    repeat (20) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(latch, 1'b0);
    check(vol, 1'b0);
    cmd(8'h06, 24'h0, 7, 1'b0, 1'b0, 1'b1);
    cmd(8'h06, 24'h0, 12, 1'b0, 1'b0, 1'b1);
    check(latch, 1'b0);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    check(latch, 1'b1);
    // every block starts locked, so a program is turned away and drops the latch
    a = {5'h00, 7'($urandom()), 12'($urandom())};
    cmd(8'h02, a, 32, 1'b0, 1'b1, 1'b0);
    check(latch, 1'b0);
    cmd(8'h39, a, 32, 1'b0, 1'b1, 1'b0);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h36, 24'h0, 24, 1'b0, 1'b0, 1'b1);
    check(latch, 1'b1);
    cmd(8'h39, a, 32, 1'b1, 1'b0, 1'b0);
    locks[a[18:12]] = 1'b0;
    check(latch, 1'b0);
    check(op, 8'h39);
    check(addr, a);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h04, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    check(latch, 1'b0);
    // every guarded opcode is refused while the latch is clear
    foreach (gops[i]) cmd(gops[i], a, gops[i][3:0] == 4'h1 ? 16 :
      (gops[i] == 8'h60 || gops[i] == 8'hC7) ? 8 : 32, 1'b0, 1'b1, 1'b0);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h02, a, 32, 1'b1, 1'b0, 1'b0);
    check(op, 8'h02);
    check(addr, a);
    // padded or short frames abort; chip erase and a latch-backed status write run
    cmd(8'h06, 24'h0, 16, 1'b0, 1'b0, 1'b1);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h02, a, 16, 1'b0, 1'b0, 1'b1);
    check(latch, 1'b1);
    cmd(8'hC7, 24'h0, 8, 1'b1, 1'b0, 1'b0);
    check(op, 8'hC7);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h31, 24'h0, 16, 1'b1, 1'b0, 1'b0);
    check(cvol, 1'b0);
    check(latch, 1'b0);
    // each status write opcode goes through once volatile enable is pending
    foreach (gops[i]) if (i > 10) begin
      cmd(8'h50, 24'h0, 8, 1'b0, 1'b0, 1'b0);
      check(vol, 1'b1);
      check(latch, 1'b0);
      cmd(gops[i], 24'($urandom()), 16, 1'b1, 1'b0, 1'b0);
      check(cvol, 1'b1);
      check(vol, 1'b0);
    end
    cmd(8'h01, 24'h0, 16, 1'b0, 1'b1, 1'b0);
    cmd(8'h50, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    check(vol, 1'b0);
    // random lock traffic judged against the bench's own lock map
    repeat (24) begin
      b = 7'($urandom());
      a = {5'h00, b, 12'($urandom())};
      cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
      if ($urandom() % 2) begin
        cmd(8'h36, a, 32, 1'b1, 1'b0, 1'b0);
        locks[b] = 1'b1;
      end else begin
        cmd(8'h39, a, 32, 1'b1, 1'b0, 1'b0);
        locks[b] = 1'b0;
      end
      @(posedge ref_clk_i) bps <= 1'($urandom());
      rng <= 1'($urandom());
      cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
      a[11:0] = 12'($urandom());
      cmd(($urandom() % 2) ? 8'h20 : 8'h02, a, 32, prog_ok(1'b1, b), !prog_ok(1'b1, b),
        1'b0);
    end
    // a reset in mid-run relocks every block and drops both enables
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h39, a, 32, 1'b1, 1'b0, 1'b0);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h50, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    check(latch, 1'b1);
    check(vol, 1'b1);
    reset_n_i <= 1'b0;
    bps <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    foreach (locks[i]) locks[i] = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check(latch, 1'b0);
    check(vol, 1'b0);
    cmd(8'h06, 24'h0, 8, 1'b0, 1'b0, 1'b0);
    cmd(8'h02, a, 32, prog_ok(1'b1, a[18:12]), !prog_ok(1'b1, a[18:12]), 1'b0);
    conclude();
  end
  // a hang is cut short well past the expected run length
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    fails++;
    conclude();
  end
endmodule
